// file: include/ubr_defines.svh
// Purpose: Offsets, indices and reset values of the banked register map.
// Assumes: Included by bare name; definitions only.
// Notes: Offsets are 3-bit bus offsets; indices are window pointer values.
`ifndef UBR_DEFINES_SVH
`define UBR_DEFINES_SVH
`define UBR_OFS_DATA 3'h0
`define UBR_OFS_IEN 3'h1
`define UBR_OFS_FIFO 3'h2
`define UBR_OFS_LCTL 3'h3
`define UBR_OFS_MCTL 3'h4
`define UBR_OFS_LSTAT 3'h5
`define UBR_OFS_MSTAT 3'h6
`define UBR_OFS_SCR 3'h7
`define UBR_LCTL_ENH_KEY 8'hbf
`define UBR_LCTL_DLAB_BIT 7
`define UBR_ACTL_BANK_BIT 7
`define UBR_ACTL_RDEN_BIT 6
`define UBR_IDX_ACTL 8'h00
`define UBR_IDX_PRESC 8'h01
`define UBR_IDX_OVS 8'h02
`define UBR_IDX_CKSEL 8'h03
`define UBR_IDX_TXLVL 8'h04
`define UBR_IDX_RXLVL 8'h05
`define UBR_IDX_FLOWLO 8'h06
`define UBR_IDX_FLOWHI 8'h07
`define UBR_IDX_IDENT1 8'h08
`define UBR_IDX_IDENT2 8'h09
`define UBR_IDX_IDENT3 8'h0a
`define UBR_IDX_REVNUM 8'h0b
`define UBR_IDX_CHRST 8'h0c
`define UBR_IDX_NINTH 8'h0d
`define UBR_IDX_WAKE 8'h0e
`define UBR_IDX_FIFORB 8'h0f
`define UBR_IDX_GOOD 8'h10
`define UBR_IDX_DMA 8'h11
`define UBR_IDX_PORT 8'h12
`define UBR_IDX_CKINV 8'h13
`define UBR_RST_ZERO 8'h00
`define UBR_RST_DIVLO 8'h01
`define UBR_RST_PRESC 8'h20
`define UBR_RST_LSTAT 8'h60
`define UBR_RST_ISRC 8'h01
`define UBR_RST_GOOD 8'h01
`define UBR_RST_DMA 8'h02
`define UBR_PORT_INDEX 8'h00
`define UBR_OVS_DEFAULT 5'h10
`define UBR_OVS_MIN 4'h4
`define UBR_ASTAT_WMASK 8'h03
`define UBR_LVL_MASK 8'h7f
`endif

// file: include/ubr_pkg.sv
// Purpose: Types of the banked register map.
// Assumes: Nothing.
// Notes: Bank codes are not ordered by precedence; the decoder sets precedence.
package ubr_pkg;
   typedef enum logic [1:0] {
      UBR_BANK_STD = 2'b00,
      UBR_BANK_ENH = 2'b01,
      UBR_BANK_DIV = 2'b10,
      UBR_BANK_EXT = 2'b11
   } ubr_bank_t;
endpackage

// file: core/ubr_regmap.sv
// Purpose: Banked register file and 3-bit offset decoder of a UART channel.
// Assumes: Host target controller presents single-cycle accesses on clk.
// Notes: Serial engine, FIFOs and interrupt logic live elsewhere; their state
// arrives on status inputs and their settings leave on register outputs.
// Overview of operation
// - Decode 3-bit offset; banks pick overlapping registers.
// - Divisor latch bit maps divisor bytes at 000/001.
// - Data and interrupt enable need divisor bit clear.
// - Writing 0xBF sets bit 7 only.
// - Key value maps enhanced and flow characters.
// - Key value hides extended registers and standard ones except line control.
// - Bank bit maps additional status and levels.
// - Interrupt enable only while bank bit clear.
// - Modem control read only with bank bit clear; line control also under key.
// - Window read needs read enable; else line status.
// - Additional status writes touch bits 0,1 only.
// - Reset loads zero; divisor low 0x01, prescaler 0x20.
// - Status reset values: 0x60, 0x01, levels zero.
// - Serial, request, ready outputs idle high.
// - Index 0x0C zero write resets, keeps clock selects.
// - Trigger levels are seven bits; bit 7 reads zero.
// - Port index and identity bytes are hardwired.
// - Prescaler holds integer M and fraction N.
// - Oversampling 0-3 means sixteen, else written count.
`timescale 1ns/1ps
`include "ubr_defines.svh"
module ubr_regmap #(
   parameter logic [7:0] ID_BYTE1 = 8'h11, // Arbitrary value.
   parameter logic [7:0] ID_BYTE2 = 8'h22, // Arbitrary value.
   parameter logic [7:0] ID_BYTE3 = 8'h33, // Arbitrary value.
   parameter logic [7:0] REVISION_BYTE = 8'h01 // Arbitrary value.
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [2:0] addr,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic tx_wr_pulse,
   output logic rx_rd_pulse,
   output logic fifo_wr_pulse,
   output logic [7:0] tx_data,
   input wire logic [7:0] rx_data,
   input wire logic [7:0] line_status_in,
   input wire logic [7:0] int_source_in,
   input wire logic [7:0] modem_status_in,
   input wire logic [7:0] rx_level_in,
   input wire logic [7:0] tx_level_in,
   input wire logic [7:2] astat_in,
   input wire logic good_data_in,
   input wire logic [1:0] dma_ready_in,
   input wire logic serial_bit,
   output logic serial_data_out,
   output logic req_to_send_n,
   output logic term_ready_n,
   output logic chan_reset,
   output logic [15:0] divisor,
   output logic [7:0] line_control,
   output logic [7:0] modem_control,
   output logic [7:0] interrupt_enable,
   output logic [7:0] fifo_control,
   output logic [7:0] enhanced_features,
   output logic [7:0] additional_control,
   output logic [4:0] presc_int,
   output logic [2:0] presc_frac,
   output logic [4:0] oversample,
   output logic [7:0] clock_source_select,
   output logic [6:0] tx_irq_level,
   output logic [6:0] rx_irq_level,
   output logic [6:0] flow_low_level,
   output logic [6:0] flow_high_level,
   output logic [7:0] ninth_bit_mode,
   output logic [7:0] wakeup_disable,
   output logic [2:0] clock_invert,
   output logic [1:0] astat_ctl,
   output logic [1:0] dma_ctl
);

   ////////////////////////////////////////////////////////////////////////////
   // Bank selection.
   logic key_r;
   logic [7:0] lctl_r, divlo_r, divhi_r, ien_r, fifo_r, enh_r, mctl_r, scr_r;
   logic [7:0] fres1_r, fres2_r, fpau1_r, fpau2_r, actl_r, presc_r, ovs_r;
   logic [7:0] cksel_r, txlvl_r, rxlvl_r, flowlo_r, flowhi_r, ninth_r, wake_r, ckinv_r;
   logic [1:0] astat_r, dma_r;
   logic soft_rst_r;
   ubr_pkg::ubr_bank_t bank;
   logic rst_all;
   logic rd_en_win;

   // The key condition outranks the divisor bit, which outranks the bank bit.
   always_comb begin
      if (key_r) begin
         bank = ubr_pkg::UBR_BANK_ENH;
      end else if (lctl_r[`UBR_LCTL_DLAB_BIT]) begin
         bank = ubr_pkg::UBR_BANK_DIV;
      end else if (actl_r[`UBR_ACTL_BANK_BIT]) begin
         bank = ubr_pkg::UBR_BANK_EXT;
      end else begin
         bank = ubr_pkg::UBR_BANK_STD;
      end
   end

   // Soft reset clears the channel one cycle after the write; clock selects survive.
   assign rst_all = sys_rst | soft_rst_r;
   assign rd_en_win = actl_r[`UBR_ACTL_RDEN_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // Write decode. Each register is written only in the bank where it is mapped.
   logic w_data, w_ien, w_divlo, w_divhi, w_fifo, w_enh, w_lctl, w_mctl;
   logic w_fres1, w_fres2, w_fpau1, w_fpau2, w_astat, w_win, w_scr;

   always_comb begin
      w_data = 1'b0; w_ien = 1'b0; w_divlo = 1'b0; w_divhi = 1'b0;
      w_fifo = 1'b0; w_enh = 1'b0; w_lctl = 1'b0; w_mctl = 1'b0;
      w_fres1 = 1'b0; w_fres2 = 1'b0; w_fpau1 = 1'b0; w_fpau2 = 1'b0;
      w_astat = 1'b0; w_win = 1'b0; w_scr = 1'b0;
      if (wr_en) begin
         unique case (addr)
            `UBR_OFS_DATA: begin
               w_divlo = (bank == ubr_pkg::UBR_BANK_DIV);
               w_data = (bank == ubr_pkg::UBR_BANK_STD) || (bank == ubr_pkg::UBR_BANK_EXT);
            end
            `UBR_OFS_IEN: begin
               w_divhi = (bank == ubr_pkg::UBR_BANK_DIV);
               w_ien = (bank == ubr_pkg::UBR_BANK_STD);
               w_astat = (bank == ubr_pkg::UBR_BANK_EXT);
            end
            `UBR_OFS_FIFO: begin
               w_enh = (bank == ubr_pkg::UBR_BANK_ENH);
               w_fifo = !key_r;
            end
            `UBR_OFS_LCTL: w_lctl = 1'b1;
            `UBR_OFS_MCTL: begin
               w_fres1 = key_r;
               w_mctl = !key_r;
            end
            `UBR_OFS_LSTAT: begin
               w_fres2 = key_r;
               w_win = !key_r;
            end
            `UBR_OFS_MSTAT: w_fpau1 = key_r;
            `UBR_OFS_SCR: begin
               w_fpau2 = key_r;
               w_scr = !key_r;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line control and the key flag; the key only changes on a line control write.
   always_ff @(posedge clk) begin
      if (rst_all) begin
         lctl_r <= `UBR_RST_ZERO;
         key_r <= 1'b0;
      end else if (w_lctl) begin
         key_r <= (wr_data == `UBR_LCTL_ENH_KEY);
         if (wr_data == `UBR_LCTL_ENH_KEY) begin
            lctl_r[`UBR_LCTL_DLAB_BIT] <= 1'b1;
         end else begin
            lctl_r <= wr_data;
         end
      end
   end

   // Standard and enhanced set, all reset to zero except the low divisor byte.
   always_ff @(posedge clk) begin
      if (rst_all) begin
         divlo_r <= `UBR_RST_DIVLO;
         divhi_r <= `UBR_RST_ZERO;
         ien_r <= `UBR_RST_ZERO;
         fifo_r <= `UBR_RST_ZERO;
         enh_r <= `UBR_RST_ZERO;
         mctl_r <= `UBR_RST_ZERO;
         scr_r <= `UBR_RST_ZERO;
         fres1_r <= `UBR_RST_ZERO;
         fres2_r <= `UBR_RST_ZERO;
         fpau1_r <= `UBR_RST_ZERO;
         fpau2_r <= `UBR_RST_ZERO;
         astat_r <= 2'b00;
      end else begin
         if (w_divlo) divlo_r <= wr_data;
         if (w_divhi) divhi_r <= wr_data;
         if (w_ien) ien_r <= wr_data;
         if (w_fifo) fifo_r <= wr_data;
         if (w_enh) enh_r <= wr_data;
         if (w_mctl) mctl_r <= wr_data;
         if (w_scr) scr_r <= wr_data;
         if (w_fres1) fres1_r <= wr_data;
         if (w_fres2) fres2_r <= wr_data;
         if (w_fpau1) fpau1_r <= wr_data;
         if (w_fpau2) fpau2_r <= wr_data;
         if (w_astat) astat_r <= wr_data[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Indexed set written through the window; the pointer picks the target.
   logic wi_chrst;
   assign wi_chrst = w_win && (scr_r == `UBR_IDX_CHRST) && (wr_data == `UBR_RST_ZERO);

   always_ff @(posedge clk) begin
      if (rst_all) begin
         actl_r <= `UBR_RST_ZERO;
         presc_r <= `UBR_RST_PRESC;
         ovs_r <= `UBR_RST_ZERO;
         txlvl_r <= `UBR_RST_ZERO;
         rxlvl_r <= `UBR_RST_ZERO;
         flowlo_r <= `UBR_RST_ZERO;
         flowhi_r <= `UBR_RST_ZERO;
         ninth_r <= `UBR_RST_ZERO;
         wake_r <= `UBR_RST_ZERO;
         dma_r <= 2'b00;
      end else if (w_win) begin
         unique case (scr_r)
            `UBR_IDX_ACTL: actl_r <= wr_data;
            `UBR_IDX_PRESC: presc_r <= wr_data;
            `UBR_IDX_OVS: ovs_r <= wr_data & 8'h0f;
            `UBR_IDX_TXLVL: txlvl_r <= wr_data & `UBR_LVL_MASK;
            `UBR_IDX_RXLVL: rxlvl_r <= wr_data & `UBR_LVL_MASK;
            `UBR_IDX_FLOWLO: flowlo_r <= wr_data & `UBR_LVL_MASK;
            `UBR_IDX_FLOWHI: flowhi_r <= wr_data & `UBR_LVL_MASK;
            `UBR_IDX_NINTH: ninth_r <= wr_data;
            `UBR_IDX_WAKE: wake_r <= wr_data & 8'h3f;
            `UBR_IDX_DMA: dma_r <= wr_data[3:2];
            default: ;
         endcase
      end
   end

   // Clock selects answer only to the hardware reset.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cksel_r <= `UBR_RST_ZERO;
         ckinv_r <= `UBR_RST_ZERO;
      end else if (w_win && scr_r == `UBR_IDX_CKSEL) begin
         cksel_r <= wr_data;
      end else if (w_win && scr_r == `UBR_IDX_CKINV) begin
         ckinv_r <= wr_data & 8'h07;
      end
   end

   // The channel reset is a one-cycle pulse, so it cannot hold itself.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         soft_rst_r <= 1'b0;
      end else begin
         soft_rst_r <= wi_chrst;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer, registered so data is steady one cycle after the read.
   logic [7:0] win_rd, rd_nxt;

   always_comb begin
      unique case (scr_r)
         `UBR_IDX_ACTL: win_rd = actl_r;
         `UBR_IDX_PRESC: win_rd = presc_r;
         `UBR_IDX_OVS: win_rd = ovs_r;
         `UBR_IDX_CKSEL: win_rd = cksel_r;
         `UBR_IDX_TXLVL: win_rd = txlvl_r;
         `UBR_IDX_RXLVL: win_rd = rxlvl_r;
         `UBR_IDX_FLOWLO: win_rd = flowlo_r;
         `UBR_IDX_FLOWHI: win_rd = flowhi_r;
         `UBR_IDX_IDENT1: win_rd = ID_BYTE1;
         `UBR_IDX_IDENT2: win_rd = ID_BYTE2;
         `UBR_IDX_IDENT3: win_rd = ID_BYTE3;
         `UBR_IDX_REVNUM: win_rd = REVISION_BYTE;
         `UBR_IDX_NINTH: win_rd = ninth_r;
         `UBR_IDX_WAKE: win_rd = wake_r;
         `UBR_IDX_FIFORB: win_rd = fifo_r;
         `UBR_IDX_GOOD: win_rd = {7'h00, good_data_in};
         `UBR_IDX_DMA: win_rd = {4'h0, dma_r, dma_ready_in};
         `UBR_IDX_PORT: win_rd = `UBR_PORT_INDEX;
         `UBR_IDX_CKINV: win_rd = ckinv_r;
         default: win_rd = 8'h00;
      endcase
   end

   always_comb begin
      rd_nxt = 8'h00;
      unique case (addr)
         `UBR_OFS_DATA: begin
            if (bank == ubr_pkg::UBR_BANK_DIV) rd_nxt = divlo_r;
            else if (bank != ubr_pkg::UBR_BANK_ENH) rd_nxt = rx_data;
         end
         `UBR_OFS_IEN: begin
            if (bank == ubr_pkg::UBR_BANK_DIV) rd_nxt = divhi_r;
            else if (bank == ubr_pkg::UBR_BANK_STD) rd_nxt = ien_r;
            else if (bank == ubr_pkg::UBR_BANK_EXT) rd_nxt = {astat_in, astat_r};
         end
         `UBR_OFS_FIFO: rd_nxt = key_r ? enh_r : int_source_in;
         `UBR_OFS_LCTL: begin
            if (!key_r && actl_r[`UBR_ACTL_BANK_BIT]) rd_nxt = rx_level_in;
            else rd_nxt = lctl_r;
         end
         `UBR_OFS_MCTL: begin
            if (key_r) rd_nxt = fres1_r;
            else if (actl_r[`UBR_ACTL_BANK_BIT]) rd_nxt = tx_level_in;
            else rd_nxt = mctl_r;
         end
         `UBR_OFS_LSTAT: begin
            if (key_r) rd_nxt = fres2_r;
            else if (rd_en_win) rd_nxt = win_rd;
            else rd_nxt = line_status_in;
         end
         `UBR_OFS_MSTAT: rd_nxt = key_r ? fpau1_r : modem_status_in;
         `UBR_OFS_SCR: rd_nxt = key_r ? fpau2_r : scr_r;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         rd_data <= rd_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Strobes to the serial engine and its FIFOs.
   assign tx_wr_pulse = w_data;
   assign fifo_wr_pulse = w_fifo;
   assign rx_rd_pulse = rd_en && (addr == `UBR_OFS_DATA) &&
                        ((bank == ubr_pkg::UBR_BANK_STD) || (bank == ubr_pkg::UBR_BANK_EXT));
   assign chan_reset = rst_all;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tx_data <= 8'h00;
      end else if (w_data) begin
         tx_data <= wr_data;
      end
   end

   // Pins idle high in reset; break and modem bits drive them otherwise.
   always_ff @(posedge clk) begin
      if (rst_all) begin
         serial_data_out <= 1'b1;
         req_to_send_n <= 1'b1;
         term_ready_n <= 1'b1;
      end else begin
         serial_data_out <= serial_bit & ~lctl_r[6];
         req_to_send_n <= ~mctl_r[1];
         term_ready_n <= ~mctl_r[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Settings toward the serial engine.
   assign divisor = {divhi_r, divlo_r};
   assign line_control = lctl_r;
   assign modem_control = mctl_r;
   assign interrupt_enable = ien_r;
   assign fifo_control = fifo_r;
   assign enhanced_features = enh_r;
   assign additional_control = actl_r;
   assign presc_int = presc_r[7:3];
   assign presc_frac = presc_r[2:0];
   // Counts below four are meaningless, so they fall back to sixteen.
   assign oversample = (ovs_r[3:0] < `UBR_OVS_MIN) ? `UBR_OVS_DEFAULT : {1'b0, ovs_r[3:0]};
   assign clock_source_select = cksel_r;
   assign tx_irq_level = txlvl_r[6:0];
   assign rx_irq_level = rxlvl_r[6:0];
   assign flow_low_level = flowlo_r[6:0];
   assign flow_high_level = flowhi_r[6:0];
   assign ninth_bit_mode = ninth_r;
   assign wakeup_disable = wake_r;
   assign clock_invert = ckinv_r[2:0];
   assign astat_ctl = astat_r;
   assign dma_ctl = dma_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence key_write_s;
      wr_en && addr == `UBR_OFS_LCTL && wr_data == `UBR_LCTL_ENH_KEY;
   endsequence

   key_keeps_format_a: assert property (@(posedge clk) disable iff (sys_rst)
      key_write_s |=> key_r && lctl_r[7] && lctl_r[6:0] == $past(lctl_r[6:0]))
      else $error("Key write changed format bits.");
   key_hides_ien_a: assert property (@(posedge clk) disable iff (sys_rst)
      key_r |-> !w_ien && !w_fifo && !w_scr && !w_win && !w_mctl)
      else $error("Standard register written under key.");
   div_low_map_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_en && addr == 3'h0 && !key_r && lctl_r[7]) |=> divisor[7:0] == $past(wr_data))
      else $error("Divisor low byte not written.");
   astat_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      w_astat |=> astat_ctl == $past(wr_data[1:0]))
      else $error("Status write bits wrong.");
   level_bit7_a: assert property (@(posedge clk) disable iff (sys_rst)
      txlvl_r[7] == 1'b0 && rxlvl_r[7] == 1'b0 && flowlo_r[7] == 1'b0 && flowhi_r[7] == 1'b0)
      else $error("Trigger level bit 7 set.");
   pins_idle_a: assert property (@(posedge clk)
      rst_all |=> serial_data_out && req_to_send_n && term_ready_n)
      else $error("Pins not idle after reset.");
   soft_rst_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      wi_chrst |=> ##1 presc_r == `UBR_RST_PRESC && cksel_r == $past(cksel_r, 2) && ckinv_r == $past(ckinv_r, 2))
      else $error("Channel reset wrong.");
   ovs_map_a: assert property (@(posedge clk) disable iff (sys_rst)
      (ovs_r[3:2] == 2'b00) ? (oversample == 5'h10) : (!oversample[4] && oversample[3:0] == ovs_r[3:0]))
      else $error("Oversampling map wrong.");
   win_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      (rd_en && addr == 3'h5 && !key_r && !rd_en_win) |=> rd_data == $past(line_status_in))
      else $error("Line status not returned.");
endmodule

// file: sim/ubr_host.sv
// Purpose: Host target controller model that issues register accesses.
// Assumes: Strobes change 1 ns after the rising edge and last one cycle.
// Notes: Keeps its own copy of the additional control byte.
`timescale 1ns/1ps
module ubr_host (
   input wire logic clk,
   output logic [2:0] addr,
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   logic [7:0] actl_copy;
   // Idle bus values at time zero.
   initial begin
      addr = 3'h0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      wr_data = 8'h00;
      actl_copy = 8'h00;
   end
   // Idle data is inverted so that a stale value is never mistaken for a write.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      addr = a;
      wr_data = d;
      wr_en = 1'b1;
      @(posedge clk) #1;
      wr_en = 1'b0;
      wr_data = ~d;
   endtask
   // Read data is registered at the taking edge and stands until the next read.
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk) #1;
      addr = a;
      rd_en = 1'b1;
      @(posedge clk) #1;
      rd_en = 1'b0;
      d = rd_data;
   endtask
   // Index first, then the value through the window.
   task automatic iwr(input logic [7:0] i, input logic [7:0] d);
      wr(3'h7, i);
      wr(3'h5, d);
      if (i == 8'h00) begin
         actl_copy = d;
      end
      if (i == 8'h0c && d == 8'h00) begin
         actl_copy = 8'h00;
      end
   endtask
   // The control byte cannot be read back here, so the local copy is rewritten.
   task automatic ird(input logic [7:0] i, output logic [7:0] d);
      iwr(8'h00, actl_copy | 8'h40);
      wr(3'h7, i);
      rd(3'h5, d);
      iwr(8'h00, actl_copy & 8'hbf);
   endtask
endmodule

// file: sim/tb_top.sv
// Purpose: Self-checking bench of the banked register map.
// Assumes: Identity parameters keep their defaults.
// Notes: Status inputs carry random levels from a fixed seed.
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] addr;
   logic wr_en, rd_en, good_data_in, serial_bit, serial_data_out, req_to_send_n, term_ready_n;
   logic [7:0] wr_data, rd_data, tx_data, rx_data, line_status_in, int_source_in, modem_status_in;
   logic [7:0] rx_level_in, tx_level_in, line_control, interrupt_enable, fifo_control;
   logic [7:0] enhanced_features, clock_source_select, additional_control, modem_control;
   logic [7:2] astat_in;
   logic [1:0] dma_ready_in, astat_ctl;
   logic [15:0] divisor;
   logic [4:0] presc_int, oversample;
   logic [2:0] presc_frac, clock_invert;
   logic [6:0] tx_irq_level;
   int num_errors = 0;
   int total_checks = 0;
   int seed = 99;
   always #4 clk = ~clk;
   ubr_host h (.clk, .addr, .wr_en, .rd_en, .wr_data, .rd_data);
   ubr_regmap dut (.clk, .sys_rst, .addr, .wr_en, .rd_en, .wr_data, .rd_data, .tx_wr_pulse(), .rx_rd_pulse(),
      .fifo_wr_pulse(), .tx_data, .rx_data, .line_status_in, .int_source_in, .modem_status_in, .rx_level_in,
      .tx_level_in, .astat_in, .good_data_in, .dma_ready_in, .serial_bit, .serial_data_out, .req_to_send_n,
      .term_ready_n, .chan_reset(), .divisor, .line_control, .modem_control, .interrupt_enable, .fifo_control,
      .enhanced_features, .additional_control, .presc_int, .presc_frac, .oversample, .clock_source_select,
      .tx_irq_level, .rx_irq_level(), .flow_low_level(), .flow_high_level(), .ninth_bit_mode(),
      .wakeup_disable(), .clock_invert, .astat_ctl, .dma_ctl());
   ////////////////////////////////////////////////////////////////////////////////
   // Every compare is counted; a mismatch is reported at once.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // Counts below four still mean sixteen samples per bit.
   function automatic logic [7:0] ovs_of(input logic [3:0] v);
      return (v < 4'h4) ? 8'h10 : {4'h0, v};
   endfunction
   // Watchdog against a hung sequence.
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
   initial begin
      logic [7:0] v, w, rv;
      {rx_data, line_status_in, int_source_in, modem_status_in} = $random(seed);
      {rx_level_in, tx_level_in, astat_in, good_data_in, dma_ready_in} = 25'($random(seed));
      serial_bit = 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk({5'h00, serial_data_out, req_to_send_n, term_ready_n}, 8'h07);
      sys_rst = 1'b0;
      chk(divisor[7:0], 8'h01);
      chk({presc_int, presc_frac}, 8'h20);
      h.rd(3'h3, rv);
      chk(rv, 8'h00);
      h.rd(3'h5, rv);
      chk(rv, line_status_in);
      $display("Test reset done");
      h.wr(3'h3, 8'h80);
      for (int k = 0; k < 4; k++) begin
         v = 8'($random(seed));
         w = 8'($random(seed));
         h.wr(3'h0, v);
         h.wr(3'h1, w);
         chk(divisor[7:0], v);
         chk(divisor[15:8], w);
         h.rd(3'h1, rv);
         chk(rv, w);
      end
      chk(tx_data, 8'h00);
      chk(interrupt_enable, 8'h00);
      $display("Test divisor done");
      v = 8'($random(seed)) & 8'h7f;
      h.wr(3'h3, v);
      h.wr(3'h3, 8'hbf);
      chk(line_control, {1'b1, v[6:0]});
      h.wr(3'h2, 8'h5a);
      h.wr(3'h5, 8'ha5);
      h.rd(3'h2, rv);
      chk(rv, 8'h5a);
      chk(enhanced_features, 8'h5a);
      chk(fifo_control, 8'h00);
      h.rd(3'h5, rv);
      chk(rv, 8'ha5);
      h.rd(3'h0, rv);
      chk(rv, 8'h00);
      h.wr(3'h3, 8'h03);
      h.wr(3'h0, 8'hc3);
      chk(tx_data, 8'hc3);
      $display("Test key done");
      h.iwr(8'h01, 8'h2b);
      chk({presc_int, presc_frac}, 8'h2b);
      h.iwr(8'h04, 8'hff);
      chk({1'b0, tx_irq_level}, 8'h7f);
      for (int k = 0; k < 16; k++) begin
         h.iwr(8'h02, 8'(k));
         chk({3'h0, oversample}, ovs_of(4'(k)));
      end
      h.ird(8'h12, rv);
      chk(rv, 8'h00);
      h.ird(8'h08, rv);
      chk(rv, 8'h11);
      h.ird(8'h04, rv);
      chk(rv, 8'h7f);
      h.ird(8'h02, rv);
      chk(rv, 8'h0f);
      h.rd(3'h5, rv);
      chk(rv, line_status_in);
      $display("Test window done");
      h.iwr(8'h00, 8'h80);
      h.wr(3'h1, 8'hff);
      chk({6'h00, astat_ctl}, 8'h03);
      chk(interrupt_enable, 8'h00);
      h.rd(3'h1, rv);
      chk(rv, {astat_in, 2'h3});
      h.rd(3'h3, rv);
      chk(rv, rx_level_in);
      h.rd(3'h4, rv);
      chk(rv, tx_level_in);
      h.wr(3'h3, 8'h80);
      h.rd(3'h1, rv);
      chk(rv, w);
      $display("Test bank done");
      serial_bit = 1'b1;
      h.wr(3'h4, 8'h03);
      chk(modem_control, 8'h03);
      h.wr(3'h3, 8'h40);
      h.iwr(8'h03, 8'h5a);
      h.iwr(8'h13, 8'h05);
      chk({6'h00, req_to_send_n, term_ready_n}, 8'h00);
      chk({7'h00, serial_data_out}, 8'h00);
      h.iwr(8'h0c, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      chk(clock_source_select, 8'h5a);
      chk({5'h00, clock_invert}, 8'h05);
      chk(divisor[7:0], 8'h01);
      chk(line_control, 8'h00);
      chk(additional_control, 8'h00);
      chk({6'h00, req_to_send_n, term_ready_n}, 8'h03);
      $display("Test channel reset done");
      give_verdict();
   end
endmodule
